// ---- hv_enable_consts.vh ----
// constants for the high-voltage enable and mode control block
`ifndef HV_ENABLE_CONSTS_VH
`define HV_ENABLE_CONSTS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS     8
`define HOLD_TIME_MS      2000
`define DEBOUNCE_TIME_MS  1
`define HOLD_CYCLES       (`HOLD_TIME_MS * (1000000 / `CLK_PERIOD_NS))
`define DEBOUNCE_CYCLES   (`DEBOUNCE_TIME_MS * (1000000 / `CLK_PERIOD_NS))
`define TIMER_W           28

// ----------------------------------------
// strap bank bit positions
// ----------------------------------------
`define STRAP_POLARITY    0
`define STRAP_RESTART     1
`define STRAP_MODE_A      2
`define STRAP_MODE_B      3

// ----------------------------------------
// operating modes
// ----------------------------------------
`define MODE_STANDARD     2'h0
`define MODE_SECONDARY    2'h1
`define MODE_REMOTE       2'h2

// ----------------------------------------
// display error codes
// ----------------------------------------
`define ERR_NONE          4'h0
`define ERR_PARAM_LOCKED  4'h4
`define ERR_SECONDARY     4'h6

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADDR_W            8
`define REG_CTRL          8'h00
`define REG_STATE         8'h04
`define REG_IRQ_STAT      8'h08
`define REG_IRQ_MASK      8'h0c

// ----------------------------------------
// control and interrupt fields
// ----------------------------------------
`define CTRL_HV_ON        0
`define CTRL_HV_OFF       1
`define CTRL_ERR_CLR      2
`define IRQ_W             4
`define IRQ_HV_ON         0
`define IRQ_HV_DROP       1
`define IRQ_SECONDARY     2
`define IRQ_LOCKED        3
`define IRQ_MASK_RESET    4'h0

`endif

// ---- hold_timer.v ----
// saturating hold timer: flags a level held longer than a limit
`timescale 1ns/1ps
`include "hv_enable_consts.vh"
module hold_timer #(
	parameter [`TIMER_W-1:0] LIMIT = 28'h0000010
) (
	// clock and reset
	input  wire                clock_i,
	input  wire                rst_i,
	// held level
	input  wire                run_i,
	// limit passed
	output reg                 long_o
);

	reg [`TIMER_W-1:0] count;

	// count restarts each time the level goes away
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count  <= 28'h0000000;
			long_o <= 1'b0;
		end else if (!run_i) begin
			count  <= 28'h0000000;
			long_o <= 1'b0;
		end else if (count < LIMIT) begin
			count <= count + 28'h0000001;
		end else begin
			long_o <= 1'b1;
		end
	end

endmodule

// ---- hv_enable_mode_control.v ----
// high-voltage enable control with strap modes, interlocks and apb registers
// Notes on behaviour
// - two straps select mode zero, one, two
// - panel button and serial start or stop
// - output only with safety interlock closed
// - mode one needs remote input held low
// - mode one refused start shows secondary code
// - mode two starts on rise after long low
// - mode two stops on remote falling edge
// - mode two panel edits locked, show code
// - select at power-up in mode two enters special setup
// - restart strap re-enables output after power loss
// - polarity strap picks displayed sign
// - beep on functions unless jumper removed
// - panel start needs two second hold
`timescale 1ns/1ps
`include "hv_enable_consts.vh"
module hv_enable_mode_control #(
	parameter [`TIMER_W-1:0] HOLD_CYCLES     = `HOLD_CYCLES,
	parameter [`TIMER_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
	// clock and reset
	input  wire               clock_i,
	input  wire               rst_i,
	// straps and retained state
	input  wire [7:0]         config_strap_bank_i,
	input  wire               beeper_enable_jumper_i,
	input  wire               saved_hv_on_i,
	// interlocks and remote input
	input  wire               ground_sense_ok_i,
	input  wire               ground_fault_i,
	input  wire               remote_n_i,
	// front panel buttons
	input  wire               hv_button_i,
	input  wire               select_button_i,
	input  wire               raise_button_i,
	input  wire               lower_button_i,
	// serial commands
	input  wire               serial_hv_on_i,
	input  wire               serial_hv_off_i,
	// apb slave
	input  wire               psel_i,
	input  wire               penable_i,
	input  wire               pwrite_i,
	input  wire [`ADDR_W-1:0] paddr_i,
	input  wire [31:0]        pwdata_i,
	output reg  [31:0]        prdata_o,
	output wire               pready_o,
	output reg                pslverr_o,
	// high voltage and display
	output reg                hv_enable_o,
	output wire               interlock_open_o,
	output reg  [3:0]         error_code_o,
	output reg                special_setup_indicator_o,
	output reg                polarity_negative_o,
	output reg                beep_o,
	output reg                scroll_o,
	output reg                param_up_o,
	output reg                param_down_o,
	// interrupt
	output wire               irq_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function rise;
		input now_v;
		input old_v;
		begin
			rise = now_v & ~old_v;
		end
	endfunction

	// ----------------------------------------
	// straps captured once after reset release
	// ----------------------------------------
	reg       booted;
	reg [1:0] mode;
	reg       restart_en;
	reg       setup_mode;

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			booted              <= 1'b0;
			mode                <= `MODE_STANDARD;
			restart_en          <= 1'b0;
			setup_mode          <= 1'b0;
			polarity_negative_o <= 1'b0;
		end else if (!booted) begin
			booted <= 1'b1;
			case ({config_strap_bank_i[`STRAP_MODE_B], config_strap_bank_i[`STRAP_MODE_A]})
				2'h1:    mode <= `MODE_SECONDARY;
				2'h2:    mode <= `MODE_REMOTE;
				default: mode <= `MODE_STANDARD;
			endcase
			restart_en          <= config_strap_bank_i[`STRAP_RESTART];
			polarity_negative_o <= config_strap_bank_i[`STRAP_POLARITY];
			// setup lasts until the next power cycle, which is the next reset
			setup_mode <= select_button_i &
				(config_strap_bank_i[`STRAP_MODE_B:`STRAP_MODE_A] == `MODE_REMOTE);
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			special_setup_indicator_o <= 1'b0;
		else
			special_setup_indicator_o <= setup_mode;
	end

	// ----------------------------------------
	// remote input: sync, debounce, low timing
	// ----------------------------------------
	reg  remote_meta;
	reg  remote_sync;
	reg  remote_level;
	reg  remote_prev;
	wire remote_settled;
	wire remote_long_low;
	reg  long_low_seen;

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			remote_meta  <= 1'b1;
			remote_sync  <= 1'b1;
			remote_level <= 1'b1;
			remote_prev  <= 1'b1;
		end else begin
			remote_meta  <= remote_n_i;
			remote_sync  <= remote_meta;
			remote_prev  <= remote_level;
			if (remote_settled)
				remote_level <= remote_sync;
		end
	end

	// a level change is taken only after it stood for the debounce time
	hold_timer #(.LIMIT(DEBOUNCE_CYCLES)) u_remote_debounce (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.run_i   (remote_sync != remote_level),
		.long_o  (remote_settled)
	);

	hold_timer #(.LIMIT(HOLD_CYCLES)) u_remote_low (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.run_i   (~remote_level),
		.long_o  (remote_long_low)
	);

	wire remote_rise = rise(remote_level, remote_prev);
	wire remote_fall = rise(remote_prev, remote_level);

	// remembers that the low phase was long enough, so the rise can start
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			long_low_seen <= 1'b0;
		else if (remote_long_low)
			long_low_seen <= 1'b1;
		else if (remote_level)
			long_low_seen <= 1'b0;
	end

	// ----------------------------------------
	// front panel buttons
	// ----------------------------------------
	reg  hv_btn_prev;
	reg  sel_prev;
	reg  raise_prev;
	reg  lower_prev;
	reg  hv_long_prev;
	wire hv_btn_long;

	hold_timer #(.LIMIT(HOLD_CYCLES)) u_button_hold (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.run_i   (hv_button_i & ~hv_enable_o),
		.long_o  (hv_btn_long)
	);

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			hv_btn_prev  <= 1'b0;
			sel_prev     <= 1'b0;
			raise_prev   <= 1'b0;
			lower_prev   <= 1'b0;
			hv_long_prev <= 1'b0;
		end else begin
			hv_btn_prev  <= hv_button_i;
			sel_prev     <= select_button_i;
			raise_prev   <= raise_button_i;
			lower_prev   <= lower_button_i;
			hv_long_prev <= hv_btn_long;
		end
	end

	// presses are ignored until boot, so a button held through reset gives no false edge
	wire panel_start = rise(hv_btn_long, hv_long_prev);
	wire panel_stop  = booted & rise(hv_button_i, hv_btn_prev) & hv_enable_o;
	wire sel_press   = booted & rise(select_button_i, sel_prev);
	wire raise_press = booted & rise(raise_button_i, raise_prev);
	wire lower_press = booted & rise(lower_button_i, lower_prev);
	wire edit_press  = raise_press | lower_press;
	wire edit_locked = (mode == `MODE_REMOTE) & ~setup_mode;

	// ----------------------------------------
	// start and stop decisions
	// ----------------------------------------
	reg  sw_on;
	reg  sw_off;
	reg  restart_done;
	wire restart_req = booted & ~restart_done & restart_en & saved_hv_on_i;
	wire interlock_ok   = ground_sense_ok_i & ~ground_fault_i;
	wire secondary_open = (mode == `MODE_SECONDARY) & remote_level;
	wire remote_start   = (mode == `MODE_REMOTE) & remote_rise & long_low_seen;
	wire remote_stop    = (mode == `MODE_REMOTE) & remote_fall & hv_enable_o;
	wire start_req = booted & (panel_start | serial_hv_on_i | sw_on |
		remote_start | restart_req);
	wire stop_req  = panel_stop | serial_hv_off_i | sw_off |
		remote_stop;
	wire drop_now  = ~interlock_ok | secondary_open;
	wire start_ok  = start_req & ~stop_req & ~drop_now & ~hv_enable_o;
	wire refuse_sec = start_req & ~hv_enable_o & secondary_open & interlock_ok;
	wire dropped   = hv_enable_o & (drop_now | stop_req);

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			restart_done <= 1'b0;
		else if (booted)
			restart_done <= 1'b1; // only the first cycle after power-up may restart
	end

	assign interlock_open_o = ~ground_sense_ok_i;

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			hv_enable_o <= 1'b0;
		else if (drop_now)
			hv_enable_o <= 1'b0;
		else if (stop_req)
			hv_enable_o <= 1'b0;
		else if (start_ok)
			hv_enable_o <= 1'b1;
	end

	// ----------------------------------------
	// display error code and panel actions
	// ----------------------------------------
	reg clr_err;

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			error_code_o <= `ERR_NONE;
		else if (refuse_sec)
			error_code_o <= `ERR_SECONDARY;
		else if (edit_press & edit_locked)
			error_code_o <= `ERR_PARAM_LOCKED;
		else if (start_ok | clr_err)
			error_code_o <= `ERR_NONE;
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scroll_o     <= 1'b0;
			param_up_o   <= 1'b0;
			param_down_o <= 1'b0;
			beep_o       <= 1'b0;
		end else begin
			scroll_o     <= sel_press;
			param_up_o   <= raise_press & ~edit_locked;
			param_down_o <= lower_press & ~edit_locked;
			beep_o       <= beeper_enable_jumper_i &
				(sel_press | edit_press | panel_start | panel_stop);
		end
	end

	// ----------------------------------------
	// apb slave: zero wait, read data latched in setup
	// ----------------------------------------
	reg  [`IRQ_W-1:0] irq_stat;
	reg  [`IRQ_W-1:0] irq_mask;
	wire setup_ph  = psel_i & ~penable_i;
	wire access_ph = psel_i & penable_i;
	wire wr_ok     = access_ph & pwrite_i & ~pslverr_o;
	wire [`IRQ_W-1:0] irq_set = {edit_press & edit_locked, refuse_sec,
		dropped, start_ok};
	reg  [`IRQ_W-1:0] irq_clr;

	assign pready_o = 1'b1;
	assign irq_o    = |(irq_stat & irq_mask);

	always @* begin
		irq_clr = {`IRQ_W{1'b0}};
		if (wr_ok && paddr_i == `REG_IRQ_STAT)
			irq_clr = pwdata_i[`IRQ_W-1:0];
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o  <= 32'h00000000;
			pslverr_o <= 1'b0;
		end else if (setup_ph) begin
			pslverr_o <= 1'b0;
			case (paddr_i)
				`REG_CTRL:
					prdata_o <= 32'h00000000;
				`REG_STATE:
					prdata_o <= {20'h00000, error_code_o, 1'b0, polarity_negative_o,
						setup_mode, remote_level, ground_sense_ok_i, mode, hv_enable_o};
				`REG_IRQ_STAT:
					prdata_o <= {28'h0000000, irq_stat};
				`REG_IRQ_MASK:
					prdata_o <= {28'h0000000, irq_mask};
				default: begin
					prdata_o  <= 32'h00000000;
					pslverr_o <= 1'b1;
				end
			endcase
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sw_on    <= 1'b0;
			sw_off   <= 1'b0;
			clr_err  <= 1'b0;
			irq_mask <= `IRQ_MASK_RESET;
			irq_stat <= {`IRQ_W{1'b0}};
		end else begin
			sw_on    <= wr_ok & (paddr_i == `REG_CTRL) & pwdata_i[`CTRL_HV_ON];
			sw_off   <= wr_ok & (paddr_i == `REG_CTRL) & pwdata_i[`CTRL_HV_OFF];
			clr_err  <= wr_ok & (paddr_i == `REG_CTRL) & pwdata_i[`CTRL_ERR_CLR];
			if (wr_ok && paddr_i == `REG_IRQ_MASK)
				irq_mask <= pwdata_i[`IRQ_W-1:0];
			// a new event wins over a clear in the same cycle
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
		end
	end

endmodule

// ---- remote_source.sv ----
// model of the remote logic source: a driver or a contact with a pull-up
`timescale 1ns/1ps
module remote_source (
	// clock
	input  wire clock_i,
	// remote line, low active
	output reg  remote_n_o
);
	// an open contact rests at the pull-up level
	initial remote_n_o = 1'b1;
	// the level stands until the next call
	task automatic drive(input logic lvl);
		@(posedge clock_i);
		remote_n_o <= lvl;
	endtask
endmodule

// ---- hv_enable_mode_control_asserts.sv ----
// assertions on the ports of the high-voltage enable block
`timescale 1ns/1ps
`include "hv_enable_consts.vh"
module hv_enable_mode_control_asserts (
	// clock and reset
	input logic       clock_i,
	input logic       rst_i,
	// inputs
	input logic [7:0] config_strap_bank_i,
	input logic       beeper_enable_jumper_i,
	input logic       ground_sense_ok_i,
	input logic       ground_fault_i,
	input logic       remote_n_i,
	input logic       hv_button_i,
	input logic       select_button_i,
	input logic       raise_button_i,
	input logic       serial_hv_on_i,
	input logic       serial_hv_off_i,
	input logic       psel_i,
	// outputs
	input logic       hv_enable_o,
	input logic       interlock_open_o,
	input logic [3:0] error_code_o,
	input logic       special_setup_indicator_o,
	input logic       polarity_negative_o,
	input logic       beep_o,
	input logic       scroll_o,
	input logic       param_up_o
);
	wire m1 = config_strap_bank_i[2] & ~config_strap_bank_i[3];
	wire m2 = ~config_strap_bank_i[2] & config_strap_bank_i[3];
	wire m0 = ~(m1 | m2);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// long enough to pass synchroniser and debounce
	sequence remote_high;
		remote_n_i [*8] ##1 remote_n_i [*4];
	endsequence
	sequence lone_start;
		serial_hv_on_i && !serial_hv_off_i && !hv_button_i && !psel_i && ground_sense_ok_i && !ground_fault_i;
	endsequence
	chk_serial_start: assert property (!$past(rst_i) && m0 ##0 lone_start |=> hv_enable_o)
		else $error("serial start ignored");
	chk_serial_stop: assert property (serial_hv_off_i |=> !hv_enable_o)
		else $error("serial stop ignored");
	chk_interlock_drop: assert property (!ground_sense_ok_i || ground_fault_i |=> !hv_enable_o)
		else $error("output kept with interlock open");
	chk_interlock_lamp: assert property (interlock_open_o == !ground_sense_ok_i)
		else $error("interlock lamp wrong");
	chk_remote_drop: assert property (m1 ##0 remote_high |=> !hv_enable_o)
		else $error("output kept with remote high");
	chk_refuse_code: assert property (m1 ##0 remote_high ##0 lone_start |=> !hv_enable_o ##[0:1]
		error_code_o == `ERR_SECONDARY) else $error("refused start not flagged");
	chk_remote_fall: assert property (m2 && $fell(remote_n_i) |-> ##[1:12] !hv_enable_o)
		else $error("remote fall did not stop output");
	chk_locked_edit: assert property (m2 && !special_setup_indicator_o && $rose(raise_button_i) |=>
		!param_up_o ##[0:1] error_code_o == `ERR_PARAM_LOCKED) else $error("locked edit not refused");
	chk_setup_mode: assert property (special_setup_indicator_o |-> m2)
		else $error("setup outside mode two");
	chk_polarity_sign: assert property (!$past(rst_i) |-> polarity_negative_o == $past(config_strap_bank_i[0]))
		else $error("sign does not follow strap");
	chk_silent_beeper: assert property (!beeper_enable_jumper_i && !$past(beeper_enable_jumper_i) |-> !beep_o)
		else $error("beep with jumper removed");
	chk_select_beep: assert property (beeper_enable_jumper_i && $rose(select_button_i) |=> scroll_o && beep_o)
		else $error("select press without scroll or beep");
endmodule
bind hv_enable_mode_control hv_enable_mode_control_asserts hv_enable_mode_control_asserts_inst (
	.clock_i, .rst_i, .config_strap_bank_i, .beeper_enable_jumper_i, .ground_sense_ok_i, .ground_fault_i,
	.remote_n_i, .hv_button_i, .select_button_i, .raise_button_i, .serial_hv_on_i, .serial_hv_off_i, .psel_i,
	.hv_enable_o, .interlock_open_o, .error_code_o, .special_setup_indicator_o, .polarity_negative_o,
	.beep_o, .scroll_o, .param_up_o
);

// ---- testbench.sv ----
// self-checking bench for the high-voltage enable block
`timescale 1ns/1ps
`include "hv_enable_consts.vh"
module testbench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int HVB = 0, SEL = 1, RAI = 2, SON = 3, SOF = 4, LOW = 5;
	logic        clock_i = 0, rst_i = 1, beeper_enable_jumper_i = 1, saved_hv_on_i = 0;
	logic        ground_sense_ok_i = 1, ground_fault_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [5:0]  btn = 6'h00;
	logic [7:0]  config_strap_bank_i = 8'h0, paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0, rd;
	wire         remote_n_i, pready_o, pslverr_o, hv_enable_o, interlock_open_o, special_setup_indicator_o;
	wire         polarity_negative_o, beep_o, scroll_o, param_up_o, param_down_o, irq_o;
	wire [31:0]  prdata_o;
	wire [3:0]   error_code_o;
	int          miscompares = 0, compares = 0, n_beep = 0, n_scr = 0, n_up = 0, n_dn = 0;
	// short counts keep the run brief
	hv_enable_mode_control #(.HOLD_CYCLES(28'h14), .DEBOUNCE_CYCLES(28'h3)) hv_enable_mode_control_inst (
		.clock_i, .rst_i, .config_strap_bank_i, .beeper_enable_jumper_i, .saved_hv_on_i, .ground_sense_ok_i,
		.ground_fault_i, .remote_n_i, .hv_button_i(btn[HVB]), .select_button_i(btn[SEL]), .raise_button_i(btn[RAI]),
		.lower_button_i(btn[LOW]), .serial_hv_on_i(btn[SON]), .serial_hv_off_i(btn[SOF]), .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .hv_enable_o, .interlock_open_o, .error_code_o,
		.special_setup_indicator_o, .polarity_negative_o, .beep_o, .scroll_o, .param_up_o, .param_down_o, .irq_o
	);
	remote_source remote_source_inst (.clock_i, .remote_n_o(remote_n_i));
	initial begin
		forever #4 clock_i = ~clock_i;
	end
	// one-cycle pulses are counted so no edge is missed
	always @(posedge clock_i) begin
		n_beep += beep_o;
		n_scr += scroll_o;
		n_up += param_up_o;
		n_dn += param_down_o;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic give_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic boot(input logic [7:0] straps, input logic sel, sv);
		rst_i <= 1'b1;
		config_strap_bank_i <= straps;
		btn[SEL] <= sel;
		saved_hv_on_i <= sv;
		tick(12);
		rst_i <= 1'b0;
		tick(4);
		btn[SEL] <= 1'b0;
	endtask
	task automatic pulse(input int b, n);
		btn[b] <= 1'b1;
		tick(n);
		btn[b] <= 1'b0;
		tick(1);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		tick(1);
		penable_i <= 1'b1;
		i = 0;
		do begin
			tick(1);
			i++;
		end while (pready_o !== 1'b1 && i < 16);
		rd = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		tick(1);
		check("pready", pready_o, 1);
		if (pready_o !== 1'b1)
			give_verdict();
	endtask
	task automatic wait_hv(input logic exp, input int bound);
		for (int i = 0; i < bound && hv_enable_o !== exp; i++)
			tick(1);
		check("hv_enable", hv_enable_o, exp);
		if (hv_enable_o !== exp)
			give_verdict();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_modes;
		logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
		for (int m = 0; m < 4; m++) begin
			boot(8'(m << 2), 0, 0);
			apb(0, `REG_STATE, 0);
			check("mode", rd[2:1], exp[m]);
		end
	endtask
	task automatic s_standard;
		boot(8'h00, 0, 0);
		check("sign", polarity_negative_o, 0);
		apb(1, `REG_IRQ_MASK, 32'h1);
		pulse(SON, 1);
		wait_hv(1, 3);
		check("irq", irq_o, 1);
		apb(1, `REG_IRQ_STAT, 32'h1);
		check("irq", irq_o, 0);
		apb(0, 8'h40, 0);
		check("slverr", pslverr_o, 1);
		ground_sense_ok_i <= 1'b0;
		wait_hv(0, 3);
		check("lamp", interlock_open_o, 1);
		ground_sense_ok_i <= 1'b1;
		pulse(HVB, 10);
		check("hv_enable", hv_enable_o, 0);
		pulse(HVB, 25);
		check("hv_enable", hv_enable_o, 1);
		pulse(SOF, 1);
		wait_hv(0, 3);
		ground_fault_i <= 1'b1;
		pulse(SON, 1);
		tick(2);
		check("hv_enable", hv_enable_o, 0);
		ground_fault_i <= 1'b0;
	endtask
	task automatic s_secondary;
		boot(8'h05, 0, 0);
		check("sign", polarity_negative_o, 1);
		tick(12);
		pulse(SON, 1);
		tick(1);
		check("hv_enable", hv_enable_o, 0);
		check("error", error_code_o, `ERR_SECONDARY);
		apb(1, `REG_CTRL, 32'h4);
		tick(2);
		check("error", error_code_o, `ERR_NONE);
		remote_source_inst.drive(0);
		tick(12);
		pulse(SON, 1);
		wait_hv(1, 3);
		remote_source_inst.drive(1);
		wait_hv(0, 14);
	endtask
	task automatic s_remote;
		int b, s, u, d;
		boot(8'h08, 0, 0);
		b = n_beep;
		s = n_scr;
		u = n_up;
		d = n_dn;
		pulse(RAI, 2);
		check("error", error_code_o, `ERR_PARAM_LOCKED);
		pulse(LOW, 2);
		pulse(SEL, 2);
		tick(1);
		check("param", n_up - u, 0);
		check("param_down", n_dn - d, 0);
		check("scroll", n_scr - s, 1);
		check("beeps", n_beep - b, 3);
		remote_source_inst.drive(0);
		tick(30);
		check("hv_enable", hv_enable_o, 0);
		remote_source_inst.drive(1);
		wait_hv(1, 14);
		remote_source_inst.drive(0);
		wait_hv(0, 14);
		remote_source_inst.drive(1);
		tick(14);
		check("hv_enable", hv_enable_o, 0);
	endtask
	task automatic s_setup;
		int b, u, d;
		boot(8'h08, 1, 0);
		check("setup", special_setup_indicator_o, 1);
		u = n_up;
		d = n_dn;
		pulse(RAI, 2);
		pulse(LOW, 2);
		check("param", n_up - u, 1);
		check("param_down", n_dn - d, 1);
		check("error", error_code_o, `ERR_NONE);
		beeper_enable_jumper_i <= 1'b0;
		tick(2);
		b = n_beep;
		pulse(SEL, 2);
		tick(1);
		check("beeps", n_beep - b, 0);
		beeper_enable_jumper_i <= 1'b1;
	endtask
	task automatic s_restart;
		for (int r = 0; r < 2; r++) begin
			boot(r ? 8'h02 : 8'h00, 0, 1);
			check("restart", hv_enable_o, r);
		end
		ground_sense_ok_i <= 1'b0;
		boot(8'h02, 0, 1);
		check("restart", hv_enable_o, 0);
		ground_sense_ok_i <= 1'b1;
	endtask
	initial begin
		s_modes();
		s_standard();
		s_secondary();
		s_remote();
		s_setup();
		s_restart();
		give_verdict();
	end
	initial begin
		tick(50000);
		miscompares++;
		give_verdict();
	end
endmodule
